/* lcd_frame_regs.svh */
// register offsets, field positions, reset values and fixed counts of the panel pixel engine
// ----------------------------------------------------------------
// Behaviour
// ----------------------------------------------------------------
// Behaviour
// - 24-bit mode drives memory bits 0..23 onto data lines D0..D23 in order.
// - pixel data leaves on the generated pixel clock; all panel timing follows it.
// - divider ratio is either 1 or 2 times (field plus one).
// - bypass set toggles the pixel clock on each generic clock cycle, with one pixel per generic clock.
// - bypass clear gives generic clock over 2 times (divider field plus 1).
// - TFT mode sends one whole pixel per pixel clock.
// - mono STN sends interface-width pixels per pixel clock.
// - colour STN sends interface-width colour components per pixel clock, three per pixel.
// - frame control register holds line count and horizontal count, both size the frame.
// - line count field is lines minus one; per half panel in dual scan.
// - mono STN horizontal count is pixels over interface width, minus one.
// - colour STN horizontal size is three times the pixel count.
// - TFT horizontal count is pixels minus one; STN fractions round up.
`ifndef LCD_FRAME_REGS_SVH
`define LCD_FRAME_REGS_SVH

`define CTRL_OFFSET 12'h000
`define FRAME_OFFSET 12'h004
`define POWER_OFFSET 12'h008
`define DMA_OFFSET 12'h00C
`define STATUS_OFFSET 12'h010
`define PIXEL_OFFSET 12'h014

`define CTRL_DIV_LSB 0
`define CTRL_DIV_MSB 8
`define CTRL_BYPASS_BIT 12
`define CTRL_MODE_LSB 16
`define CTRL_MODE_MSB 17
`define CTRL_IFW_BIT 20
`define FRAME_HOZ_LSB 0
`define FRAME_HOZ_MSB 10
`define FRAME_LINE_LSB 21
`define FRAME_LINE_MSB 31

`define CTRL_RESET 32'h0000_0000
`define FRAME_RESET 32'h0000_0000
`define POWER_RESET 1'b0
`define DMA_RESET 1'b0

`define COLOUR_PARTS 2'h3

`endif

/* lcd_frame_pkg.sv */
// types shared by the panel pixel engine
`default_nettype none
package lcd_frame_pkg;

  typedef enum logic [1:0] {
    mode_tft = 2'b00,
    mode_stn_mono = 2'b01,
    mode_stn_colour = 2'b10
  } panel_mode_t;

  typedef struct packed {
    logic [8:0] div;
    logic bypass;
    panel_mode_t mode;
    logic if_wide;
  } clk_cfg_t;

  typedef struct packed {
    logic [10:0] hoz;
    logic [10:0] line;
  } frame_cfg_t;

  typedef struct packed {
    logic [23:0] data;
    logic pclk;
    logic line_start;
    logic frame_start;
  } panel_out_t;

endpackage
`default_nettype wire

/* lcd_pixel_divider.sv */
// pixel clock enable generator with bypass and even-ratio division
`timescale 1ns/1ps
`include "lcd_frame_regs.svh"
`default_nettype none
module lcd_pixel_divider
  import lcd_frame_pkg::*;
#(
  parameter int DIV_W = 9
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic bypass,
  input wire logic [DIV_W-1:0] div,
  output logic tick,
  output logic level
);
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic phase;
  logic next_phase;
  logic next_tick;

  // ratio two times field plus one
  always_comb begin
    next_count = count;
    next_phase = phase;
    next_tick = 1'b0;
    if (!run) begin
      next_count = '0;
      next_phase = 1'b0;
    end else if (bypass) begin
      next_count = '0;
      next_phase = ~phase;
      next_tick = 1'b1;
    end else if (count == div) begin
      next_count = '0;
      next_phase = ~phase;
      next_tick = phase;
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      phase <= 1'b0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      phase <= next_phase;
      tick <= next_tick;
    end
  end

  assign level = phase;
endmodule
`default_nettype wire

/* lcd_frame_engine.sv */
// panel pixel engine: registers over AHB-Lite, pixel clock and frame sequencing
`timescale 1ns/1ps
`include "lcd_frame_regs.svh"
`default_nettype none
module lcd_frame_engine
  import lcd_frame_pkg::*;
#(
  parameter int DIV_W = 9,
  parameter int SIZE_W = 11
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [23:0] panel_data,
  output logic panel_pclk,
  output logic panel_line_start,
  output logic panel_frame_start,
  output logic panel_power,
  output logic frame_dma_enable
);
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [31:0] first_control_register;
  logic [31:0] frame_control_register;
  logic panel_power_bit;
  logic frame_dma_enable_bit;
  logic [23:0] pixel_word;
  logic [31:0] next_ctrl;
  logic [31:0] next_frame;
  logic next_power;
  logic next_dma;
  logic [23:0] next_pixel;
  logic wr_pend;
  logic next_wr_pend;
  logic [11:0] wr_addr;
  logic [11:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic [31:0] status_word;
  logic [SIZE_W-1:0] col;
  logic [SIZE_W-1:0] row;
  logic [1:0] part;
  logic in_frame;

  always_comb begin
    next_ctrl = first_control_register;
    next_frame = frame_control_register;
    next_power = panel_power_bit;
    next_dma = frame_dma_enable_bit;
    next_pixel = pixel_word;
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_hrdata = hrdata;
    if (wr_pend) begin
      case (wr_addr)
        `CTRL_OFFSET: begin
          next_ctrl = hwdata;
        end
        // both size fields in one register
        `FRAME_OFFSET: begin
          next_frame = hwdata;
        end
        `POWER_OFFSET: begin
          next_power = hwdata[0];
        end
        `DMA_OFFSET: begin
          next_dma = hwdata[0];
        end
        `PIXEL_OFFSET: begin
          next_pixel = hwdata[23:0];
        end
        default: begin
        end
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      next_wr_pend = hwrite;
      next_wr_addr = haddr;
      if (!hwrite) begin
        case (haddr)
          `CTRL_OFFSET: next_hrdata = first_control_register;
          `FRAME_OFFSET: next_hrdata = frame_control_register;
          `POWER_OFFSET: next_hrdata = {31'h0000_0000, panel_power_bit};
          `DMA_OFFSET: next_hrdata = {31'h0000_0000, frame_dma_enable_bit};
          `STATUS_OFFSET: next_hrdata = status_word;
          `PIXEL_OFFSET: next_hrdata = {8'h00, pixel_word};
          default: next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      first_control_register <= `CTRL_RESET;
      frame_control_register <= `FRAME_RESET;
      panel_power_bit <= `POWER_RESET;
      frame_dma_enable_bit <= `DMA_RESET;
      pixel_word <= 24'h00_0000;
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata <= 32'h0000_0000;
    end else begin
      first_control_register <= next_ctrl;
      frame_control_register <= next_frame;
      panel_power_bit <= next_power;
      frame_dma_enable_bit <= next_dma;
      pixel_word <= next_pixel;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  clk_cfg_t ccfg;
  frame_cfg_t fcfg;
  assign ccfg.div = first_control_register[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
  assign ccfg.bypass = first_control_register[`CTRL_BYPASS_BIT];
  assign ccfg.mode = panel_mode_t'(first_control_register[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
  assign ccfg.if_wide = first_control_register[`CTRL_IFW_BIT];
  // line count is height minus one
  assign fcfg.line = frame_control_register[`FRAME_LINE_MSB:`FRAME_LINE_LSB];
  // horizontal count already reduced by software
  assign fcfg.hoz = frame_control_register[`FRAME_HOZ_MSB:`FRAME_HOZ_LSB];

  assign status_word = {row, 5'h00, col, 1'b0, part, 1'b0, in_frame};

  // ----------------------------------------------------------------
  // pixel clock
  // ----------------------------------------------------------------
  logic tick;
  logic pclk_level;
  lcd_pixel_divider #(
    .DIV_W(DIV_W)
  ) u_div (
    .clk(clk),
    .reset(reset),
    .run(panel_power_bit),
    .bypass(ccfg.bypass),
    .div(ccfg.div[DIV_W-1:0]),
    .tick(tick),
    .level(pclk_level)
  );

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  logic [SIZE_W-1:0] next_col;
  logic [SIZE_W-1:0] next_row;
  logic [1:0] next_part;
  logic next_in_frame;
  panel_out_t pout;
  panel_out_t next_pout;
  logic [23:0] shifted;

  // stn lanes carry interface width of samples
  always_comb begin
    shifted = 24'h00_0000;
    if (ccfg.if_wide) begin
      shifted[7:0] = pixel_word[7:0];
    end else begin
      shifted[3:0] = pixel_word[3:0];
    end
  end

  always_comb begin
    next_col = col;
    next_row = row;
    next_part = part;
    next_in_frame = in_frame;
    next_pout = pout;
    next_pout.pclk = ccfg.bypass ? (pout.pclk ^ tick) : pclk_level;
    next_pout.line_start = 1'b0;
    next_pout.frame_start = 1'b0;
    if (!panel_power_bit) begin
      next_col = '0;
      next_row = '0;
      next_part = 2'h0;
      next_in_frame = 1'b0;
      next_pout = '0;
    end else if (tick) begin
      next_in_frame = 1'b1;
      next_pout.line_start = (col == '0);
      next_pout.frame_start = (col == '0) && (row == '0);
      case (ccfg.mode)
        // whole 24-bit pixel per clock, bits in order
        mode_tft: begin
          next_pout.data = pixel_word;
        end
        mode_stn_mono: begin
          next_pout.data = shifted;
        end
        mode_stn_colour: begin
          next_pout.data = shifted;
        end
        default: begin
          next_pout.data = 24'h00_0000;
        end
      endcase
      // colour STN cycles three components, count already holds the 3x
      if (ccfg.mode == mode_stn_colour && part != `COLOUR_PARTS - 2'h1) begin
        next_part = part + 2'h1;
      end else begin
        next_part = 2'h0;
      end
      // one tick per horizontal count step
      if (col == fcfg.hoz) begin
        next_col = '0;
        next_part = 2'h0;
        next_row = (row == fcfg.line) ? '0 : row + 1'b1;
      end else begin
        next_col = col + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      col <= '0;
      row <= '0;
      part <= 2'h0;
      in_frame <= 1'b0;
      pout <= '0;
      panel_power <= 1'b0;
      frame_dma_enable <= 1'b0;
    end else begin
      col <= next_col;
      row <= next_row;
      part <= next_part;
      in_frame <= next_in_frame;
      pout <= next_pout;
      panel_power <= panel_power_bit;
      frame_dma_enable <= frame_dma_enable_bit;
    end
  end

  assign panel_data = pout.data;
  assign panel_pclk = pout.pclk;
  assign panel_line_start = pout.line_start;
  assign panel_frame_start = pout.frame_start;
endmodule
`default_nettype wire

/* lcd_frame_engine_properties.sv */
// assertion checker for the panel pixel engine
`timescale 1ns/1ps
`include "lcd_frame_regs.svh"
`default_nettype none
module lcd_frame_engine_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic panel_pclk,
  input wire logic panel_line_start,
  input wire logic panel_frame_start,
  input wire logic panel_power,
  input wire logic frame_dma_enable
);
  // ----
  // shadow of written setup
  // ----
  logic wph, byp, pw, de, la, fa;
  logic [11:0] wa;
  logic [8:0] dv;
  logic [10:0] hz, ln;
  logic [1:0] off;
  logic [31:0] lc, fc;
  wire [31:0] lp = (byp ? 32'h1 : 32'h2 * (dv + 32'h1)) * (hz + 32'h1);
  wire [31:0] fp = lp * (ln + 32'h1);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {wph, byp, pw, de, la, fa, wa, dv, hz, ln, off, lc, fc} <= '0;
    end else begin
      wph <= hsel && hready && htrans[1] && hwrite;
      wa <= haddr;
      if (wph && wa == `CTRL_OFFSET) begin
        dv <= hwdata[8:0];
        byp <= hwdata[12];
      end
      if (wph && wa == `FRAME_OFFSET) begin
        hz <= hwdata[10:0];
        ln <= hwdata[31:21];
      end
      if (wph && wa == `POWER_OFFSET) pw <= hwdata[0];
      if (wph && wa == `DMA_OFFSET) de <= hwdata[0];
      lc <= panel_line_start ? 32'h1 : lc + 32'h1;
      fc <= panel_frame_start ? 32'h1 : fc + 32'h1;
      la <= panel_power && (la || panel_line_start);
      fa <= panel_power && (fa || panel_frame_start);
      off <= panel_power ? 2'h0 : (off == 2'h3 ? off : off + 2'h1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_LINE_PERIOD: assert property (panel_line_start && la && !byp |-> lc == lp)
    else $error("line gap");
  AST_BYPASS_PERIOD: assert property (panel_line_start && la && byp |-> lc == lp)
    else $error("bypass gap");
  AST_FRAME_PERIOD: assert property (panel_frame_start && fa |-> fc == fp)
    else $error("frame gap");
  AST_FRAME_ON_LINE: assert property (panel_frame_start |-> panel_line_start)
    else $error("frame off line");
  AST_QUIET_OFF: assert property (off == 2'h3 |-> !panel_line_start && !panel_frame_start)
    else $error("pulse when off");
  AST_PCLK_STILL: assert property (off == 2'h3 |-> $stable(panel_pclk))
    else $error("pclk when off");
  AST_POWER_MIRROR: assert property (wph && wa == `POWER_OFFSET |-> ##2 panel_power == pw)
    else $error("power bit");
  AST_DMA_MIRROR: assert property (wph && wa == `DMA_OFFSET |-> ##2 frame_dma_enable == de)
    else $error("dma bit");
endmodule
`default_nettype wire

/* lcd_panel_model.sv */
// panel model taking pixel lines on each pixel clock rise
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  input wire logic clk,
  input wire logic panel_pclk,
  input wire logic [23:0] panel_data,
  output logic [23:0] pixel
);
  logic pq;
  always_ff @(posedge clk) begin
    pq <= panel_pclk;
    if (panel_pclk && !pq) pixel <= panel_data;
  end
endmodule
`default_nettype wire

/* lcd_frame_engine_tb.sv */
// self-checking bench for the panel pixel engine
`timescale 1ns/1ps
`include "lcd_frame_regs.svh"
`default_nettype none
module lcd_frame_engine_tb;
  logic clk = 1'h0, reset = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0, q, e;
  wire [31:0] hrdata;
  wire [23:0] panel_data, pixel;
  wire hreadyout, hresp, panel_pclk, panel_line_start, panel_frame_start, panel_power, frame_dma_enable;
  wire hready = hreadyout;
  int bad_count = 0, check_count = 0;
  logic [31:0] ctl [4] = '{32'h0000_0003, 32'h0000_1000, 32'h0011_0002, 32'h0002_0001};
  logic [31:0] frm [4] = '{32'h0020_0003, 32'h0040_0004, 32'h0020_0002, 32'h0000_0005};
  lcd_frame_engine lcd_frame_engine_i (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .panel_data, .panel_pclk, .panel_line_start, .panel_frame_start, .panel_power,
    .frame_dma_enable);
  lcd_panel_model lcd_panel_model_i (.clk, .panel_pclk, .panel_data, .pixel);
  initial forever #25 clk = ~clk;
  // ----
  // tasks
  // ----
  task automatic give_verdict;
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'h1 && n < 64);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'h1 && n < 64);
    q = hrdata;
    if (n >= 64) begin
      bad_count++;
      give_verdict;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xfer(1'h0, a, '0);
    chk(q, x);
  endtask
  task automatic gap(input logic f, input logic [31:0] x);
    int n;
    n = 0;
    while ((f ? panel_frame_start : panel_line_start) !== 1'h1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin @(posedge clk); n++; end while ((f ? panel_frame_start : panel_line_start) !== 1'h1 && n < 4000);
    chk(n, x);
    if (n >= 4000) give_verdict;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    rd(`POWER_OFFSET, '0);
    rd(`DMA_OFFSET, '0);
    // power and frame DMA off first
    xfer(1'h1, `POWER_OFFSET, '0);
    xfer(1'h1, `DMA_OFFSET, '0);
    xfer(1'h1, `DMA_OFFSET, 32'h1);
    rd(`DMA_OFFSET, 32'h1);
    chk(frame_dma_enable, 32'h1);
    xfer(1'h1, `DMA_OFFSET, '0);
    xfer(1'h1, 12'h040, 32'hFFFF_FFFF);
    rd(12'h040, '0);
    chk(hresp, '0);
    for (int i = 0; i < 4; i++) begin
      xfer(1'h1, `POWER_OFFSET, '0);
      repeat (4) @(posedge clk);
      xfer(1'h1, `CTRL_OFFSET, ctl[i]);
      xfer(1'h1, `FRAME_OFFSET, frm[i]);
      xfer(1'h1, `PIXEL_OFFSET, 32'h00C3_5A96 + i);
      rd(`CTRL_OFFSET, ctl[i]);
      rd(`FRAME_OFFSET, frm[i]);
      xfer(1'h1, `POWER_OFFSET, 32'h1);
      e = (ctl[i][12] ? 32'h1 : 32'h2 * (ctl[i][8:0] + 32'h1)) * (frm[i][10:0] + 32'h1);
      gap(1'h0, e);
      gap(1'h1, e * (frm[i][31:21] + 32'h1));
      e = 32'h00C3_5A96 + i;
      if (i < 2) chk(pixel, e);
      else chk(pixel, e & (i == 2 ? 32'h0000_00FF : 32'h0000_000F));
    end
    xfer(1'h1, `POWER_OFFSET, '0);
    repeat (8) @(posedge clk);
    chk(panel_power, '0);
    give_verdict;
  end
endmodule
bind lcd_frame_engine lcd_frame_engine_properties lcd_frame_engine_properties_i (.clk, .reset, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .panel_pclk, .panel_line_start, .panel_frame_start, .panel_power,
  .frame_dma_enable);
`default_nettype wire
